/* include/pcbx_pkg.sv */
`default_nettype none
package pcbx_pkg;

    // pin, function and slot counts, and pin index width
    localparam int NPIN  = 23;
    localparam int NFN   = 25;
    localparam int NSLOT = 19;
    localparam int PINW  = 5;

    // register word indices, byte address is four times the index
    localparam logic [9:0] IDX_ROUTE_A = 10'h0e1;
    localparam logic [9:0] IDX_ROUTE_B = 10'h0e2;
    localparam logic [9:0] IDX_ROUTE_C = 10'h0e3;
    localparam logic [9:0] IDX_SKIP0   = 10'h0d4;
    localparam logic [9:0] IDX_SKIP1   = 10'h0d5;
    localparam logic [9:0] IDX_SKIP2   = 10'h0d6;
    localparam logic [9:0] IDX_OWNED0  = 10'h0f0;
    localparam logic [9:0] IDX_OWNED1  = 10'h0f1;
    localparam logic [9:0] IDX_OWNED2  = 10'h0f2;

    // reset values
    localparam logic [7:0] RST_ROUTE_A = 8'h00;
    localparam logic [6:0] RST_ROUTE_B = 7'h00;
    localparam logic [1:0] RST_ROUTE_C = 2'h0;
    localparam logic [7:0] RST_SKIP    = 8'h00;

    // route_enable_reg_a fields
    localparam int A_ASYNC_SERIAL = 0;
    localparam int A_SYNC_A       = 1;
    localparam int A_TWOWIRE      = 2;
    localparam int A_CLOCK_OUT    = 3;
    localparam int A_CMP0_SYNC    = 4;
    localparam int A_CMP0_ASYNC   = 5;
    localparam int A_CMP1_SYNC    = 6;
    localparam int A_CMP1_ASYNC   = 7;
    // route_enable_reg_b fields
    localparam int B_CHAN_LSB     = 0;
    localparam int B_EXT_COUNT    = 3;
    localparam int B_TIMER0       = 4;
    localparam int B_TIMER1       = 5;
    localparam int B_SYNC_B       = 6;
    // route_enable_reg_c fields, stored as two bits
    localparam int C_GLOBAL_EN    = 6;
    localparam int C_WEAK_PULL_OFF = 7;

    // counter-array channel field codes, and the three-wire sync serial mode code
    localparam logic [2:0] CHAN_NONE     = 3'h0;
    localparam logic [2:0] CHAN_MAX      = 3'h5;
    localparam logic [2:0] CHAN_ALIAS    = 3'h6;
    localparam logic [2:0] CHAN_RESERVED = 3'h7;
    localparam logic [1:0] SS_3WIRE      = 2'h0;

    // fixed pin positions
    localparam logic [PINW-1:0] PIN_TX    = 5'h04;
    localparam logic [PINW-1:0] PIN_RX    = 5'h05;
    localparam logic [PINW-1:0] PIN_B_SCK = 5'h10;

    // function identifiers
    localparam logic [PINW-1:0] FN_TX       = 5'h00;
    localparam logic [PINW-1:0] FN_RX       = 5'h01;
    localparam logic [PINW-1:0] FN_SYNC_SERIAL_PORT_B_SCK = 5'h02;
    localparam logic [PINW-1:0] FN_SYNC_SERIAL_PORT_B_NSS = 5'h05;
    localparam logic [PINW-1:0] FN_SYNC_SERIAL_PORT_A_SCK = 5'h06;
    localparam logic [PINW-1:0] FN_SDA      = 5'h0a;
    localparam logic [PINW-1:0] FN_SCL      = 5'h0b;
    localparam logic [PINW-1:0] FN_CMP0     = 5'h0c;
    localparam logic [PINW-1:0] FN_CORE_CLOCK_SIGNAL   = 5'h10;
    localparam logic [PINW-1:0] FN_CEX0     = 5'h11;
    localparam logic [PINW-1:0] FN_ECI      = 5'h16;
    localparam logic [PINW-1:0] FN_NONE     = 5'h1f;

    // crossbar slot to function, in priority order
    localparam logic [PINW-1:0] SLOT_FN [NSLOT] = '{
        5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
        5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18};

    typedef struct packed {
        logic [NFN-1:0] out;
        logic [NFN-1:0] oe;
    } pcbx_fn_t;

    typedef struct packed {
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe;
    } pcbx_pad_t;

endpackage
`default_nettype wire

/* src/pcbx_pick.sv */
`timescale 1ns/10ps
`default_nettype none
module pcbx_pick (
    // free pins in
    input  wire logic [pcbx_pkg::NPIN-1:0] avail,
    input  wire logic                      req,
    // grant
    output logic                           hit,
    output logic [pcbx_pkg::PINW-1:0]      pin,
    output logic [pcbx_pkg::NPIN-1:0]      avail_left
);

    // lowest free pin wins
    always_comb begin
        hit        = 1'b0;
        pin        = '0;
        avail_left = avail;
        for (int i = 0; i < pcbx_pkg::NPIN; i++) begin
            if (req && !hit && avail[i]) begin
                hit           = 1'b1;
                pin           = pcbx_pkg::PINW'(i);
                avail_left[i] = 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* src/pcbx_top.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pcbx_top (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // peripheral side
    input  wire pcbx_pkg::pcbx_fn_t        fn_drive,
    output pcbx_pkg::pcbx_fn_t             unused_fn_dummy,
    output logic [pcbx_pkg::NFN-1:0]       fn_in,
    input  wire logic [1:0]                ssa_mode,
    input  wire logic [1:0]                ssb_mode,
    // port logic side
    input  wire logic [pcbx_pkg::NPIN-1:0] gpio_out,
    input  wire logic [pcbx_pkg::NPIN-1:0] gpio_oe,
    input  wire logic [pcbx_pkg::NPIN-1:0] pin_output_mode_select,
    input  wire logic [pcbx_pkg::NPIN-1:0] pin_digital_mode,
    output logic [pcbx_pkg::NPIN-1:0]      capture_level,
    output logic                           weak_pull_off,
    // pads
    input  wire logic [pcbx_pkg::NPIN-1:0] pad_in,
    output pcbx_pkg::pcbx_pad_t            pad
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and apb
    logic [7:0]  route_a_q, route_a_d;
    logic [6:0]  route_b_q, route_b_d;
    logic [1:0]  route_c_q, route_c_d;
    logic [7:0]  skip0_q, skip0_d;
    logic [7:0]  skip1_q, skip1_d;
    logic [7:0]  skip2_q, skip2_d;
    logic [31:0] prdata_q, prdata_d;
    logic [9:0]  idx;
    logic        addr_hit;
    logic [31:0] rd_mux;
    logic [pcbx_pkg::NPIN-1:0] owned_vec;
    assign idx     = paddr[11:2];
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = psel && penable && !addr_hit;
    assign unused_fn_dummy = '0;
    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = 32'h0;
        if (idx == pcbx_pkg::IDX_ROUTE_A) begin
            rd_mux = {24'h0, route_a_q};
        end else if (idx == pcbx_pkg::IDX_ROUTE_B) begin
            rd_mux = {25'h0, route_b_q};
        end else if (idx == pcbx_pkg::IDX_ROUTE_C) begin
            rd_mux = {24'h0, route_c_q, 6'h0};
        end else if (idx == pcbx_pkg::IDX_SKIP0) begin
            rd_mux = {24'h0, skip0_q};
        end else if (idx == pcbx_pkg::IDX_SKIP1) begin
            rd_mux = {24'h0, skip1_q};
        end else if (idx == pcbx_pkg::IDX_SKIP2) begin
            rd_mux = {24'h0, skip2_q};
        end else if (idx == pcbx_pkg::IDX_OWNED0) begin
            rd_mux = {24'h0, owned_vec[7:0]};
        end else if (idx == pcbx_pkg::IDX_OWNED1) begin
            rd_mux = {24'h0, owned_vec[15:8]};
        end else if (idx == pcbx_pkg::IDX_OWNED2) begin
            rd_mux = {25'h0, owned_vec[22:16]};
        end else begin
            addr_hit = 1'b0;
        end
    end

    always_comb begin
        route_a_d = route_a_q;
        route_b_d = route_b_q;
        route_c_d = route_c_q;
        skip0_d   = skip0_q;
        skip1_d   = skip1_q;
        skip2_d   = skip2_q;
        prdata_d  = prdata_q;
        // read data latched in setup, valid through access
        if (psel && !penable && !pwrite) begin
            prdata_d = rd_mux;
        end
        if (psel && penable && pwrite) begin
            if (idx == pcbx_pkg::IDX_ROUTE_A) begin
                route_a_d = pwdata[7:0];
            end else if (idx == pcbx_pkg::IDX_ROUTE_B) begin
                route_b_d = pwdata[6:0];
            end else if (idx == pcbx_pkg::IDX_ROUTE_C) begin
                route_c_d = pwdata[7:6];
            end else if (idx == pcbx_pkg::IDX_SKIP0) begin
                skip0_d = pwdata[7:0];
            end else if (idx == pcbx_pkg::IDX_SKIP1) begin
                skip1_d = pwdata[7:0];
            end else if (idx == pcbx_pkg::IDX_SKIP2) begin
                skip2_d = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_a_q <= pcbx_pkg::RST_ROUTE_A;
            route_b_q <= pcbx_pkg::RST_ROUTE_B;
            route_c_q <= pcbx_pkg::RST_ROUTE_C;
            skip0_q   <= pcbx_pkg::RST_SKIP;
            skip1_q   <= pcbx_pkg::RST_SKIP;
            skip2_q   <= pcbx_pkg::RST_SKIP;
            prdata_q  <= 32'h0;
        end else begin
            route_a_q <= route_a_d;
            route_b_q <= route_b_d;
            route_c_q <= route_c_d;
            skip0_q   <= skip0_d;
            skip1_q   <= skip1_d;
            skip2_q   <= skip2_d;
            prdata_q  <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // priority decode
    logic [pcbx_pkg::NPIN-1:0] skip_all;
    logic [pcbx_pkg::NPIN-1:0] free0;
    logic [pcbx_pkg::NPIN-1:0] avail_chain [pcbx_pkg::NSLOT+1];
    logic [pcbx_pkg::NSLOT-1:0] slot_req;
    logic [pcbx_pkg::NSLOT-1:0] slot_hit;
    logic [pcbx_pkg::PINW-1:0] slot_pin [pcbx_pkg::NSLOT];
    logic [pcbx_pkg::PINW-1:0] owner_d [pcbx_pkg::NPIN];
    logic [pcbx_pkg::PINW-1:0] owner_q [pcbx_pkg::NPIN];
    logic [2:0] chan_cnt;
    logic       ssa_4w;
    logic       ssb_4w;
    logic       en_q;
    // bit n of a port's mask is pin n of that port; P2.7 lies outside
    assign skip_all = {skip2_q[6:0], skip1_q, skip0_q};
    assign ssa_4w   = (ssa_mode != pcbx_pkg::SS_3WIRE);
    assign ssb_4w   = (ssb_mode != pcbx_pkg::SS_3WIRE);
    assign en_q     = route_c_q[pcbx_pkg::C_GLOBAL_EN - 6];
    assign weak_pull_off = route_c_q[pcbx_pkg::C_WEAK_PULL_OFF - 6];
    always_comb begin
        chan_cnt = route_b_q[pcbx_pkg::B_CHAN_LSB +: 3];
        if (chan_cnt == pcbx_pkg::CHAN_RESERVED) begin
            chan_cnt = pcbx_pkg::CHAN_NONE;
        end else if (chan_cnt == pcbx_pkg::CHAN_ALIAS) begin
            chan_cnt = pcbx_pkg::CHAN_MAX;
        end
        slot_req[2:0] = {3{route_a_q[pcbx_pkg::A_SYNC_A]}};
        slot_req[3]   = route_a_q[pcbx_pkg::A_SYNC_A] && ssa_4w;
        slot_req[5:4] = {2{route_a_q[pcbx_pkg::A_TWOWIRE]}};
        slot_req[6]   = route_a_q[pcbx_pkg::A_CMP0_SYNC];
        slot_req[7]   = route_a_q[pcbx_pkg::A_CMP0_ASYNC];
        slot_req[8]   = route_a_q[pcbx_pkg::A_CMP1_SYNC];
        slot_req[9]   = route_a_q[pcbx_pkg::A_CMP1_ASYNC];
        slot_req[10]  = route_a_q[pcbx_pkg::A_CLOCK_OUT];
        for (int c = 0; c < 5; c++) begin
            slot_req[11+c] = (3'(c) < chan_cnt);
        end
        slot_req[16]  = route_b_q[pcbx_pkg::B_EXT_COUNT];
        slot_req[17]  = route_b_q[pcbx_pkg::B_TIMER0];
        slot_req[18]  = route_b_q[pcbx_pkg::B_TIMER1];
    end

    // fixed ports claim their pins before the search starts
    always_comb begin
        free0 = ~skip_all;
        owner_d = '{default: pcbx_pkg::FN_NONE};
        if (route_a_q[pcbx_pkg::A_ASYNC_SERIAL]) begin
            if (!skip_all[pcbx_pkg::PIN_TX]) begin
                owner_d[pcbx_pkg::PIN_TX] = pcbx_pkg::FN_TX;
                free0[pcbx_pkg::PIN_TX]   = 1'b0;
            end
            if (!skip_all[pcbx_pkg::PIN_RX]) begin
                owner_d[pcbx_pkg::PIN_RX] = pcbx_pkg::FN_RX;
                free0[pcbx_pkg::PIN_RX]   = 1'b0;
            end
        end
        if (route_b_q[pcbx_pkg::B_SYNC_B]) begin
            for (int k = 0; k < 4; k++) begin
                if ((k < 3 || ssb_4w) && !skip_all[pcbx_pkg::PIN_B_SCK + k]) begin
                    owner_d[pcbx_pkg::PIN_B_SCK + k] = pcbx_pkg::FN_SYNC_SERIAL_PORT_B_SCK + 5'(k);
                    free0[pcbx_pkg::PIN_B_SCK + k]   = 1'b0;
                end
            end
        end
        for (int s = 0; s < pcbx_pkg::NSLOT; s++) begin
            if (slot_hit[s]) begin
                owner_d[slot_pin[s]] = pcbx_pkg::SLOT_FN[s];
            end
        end
    end
    assign avail_chain[0] = free0;
    // each slot takes the lowest pin left by the slots above it
    for (genvar s = 0; s < pcbx_pkg::NSLOT; s++) begin : g_slot
        pcbx_pick u_pick (
            .avail      (avail_chain[s]),
            .req        (slot_req[s]),
            .hit        (slot_hit[s]),
            .pin        (slot_pin[s]),
            .avail_left (avail_chain[s+1])
        );
    end
    // memory bus pins are not in this range and never seen here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owner_q <= '{default: pcbx_pkg::FN_NONE};
        end else begin
            owner_q <= owner_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad drive and input paths
    logic [pcbx_pkg::NPIN-1:0] sync1_q, sync2_q;
    logic [pcbx_pkg::NPIN-1:0] smb_mask;
    logic [pcbx_pkg::NFN-1:0]  fn_seen;
    logic [pcbx_pkg::NFN-1:0]  fn_in_d, fn_in_q;
    logic [pcbx_pkg::NPIN-1:0] cap_d, cap_q;
    pcbx_pkg::pcbx_pad_t       pad_d, pad_q;
    assign pad           = pad_q;
    assign fn_in         = fn_in_q;
    assign capture_level = cap_q;
    always_comb begin
        pad_d    = '0;
        fn_in_d  = '0;
        fn_seen  = '0;
        smb_mask = '0;
        for (int i = 0; i < pcbx_pkg::NPIN; i++) begin
            owned_vec[i] = (owner_q[i] != pcbx_pkg::FN_NONE);
            smb_mask[i]  = (owner_q[i] == pcbx_pkg::FN_SDA) || (owner_q[i] == pcbx_pkg::FN_SCL);
            if (owned_vec[i]) begin
                fn_seen[owner_q[i]] = 1'b1;
                fn_in_d[owner_q[i]] = sync2_q[i];
                pad_d.out[i] = fn_drive.out[owner_q[i]];
                pad_d.oe[i]  = fn_drive.oe[owner_q[i]];
            end else begin
                pad_d.out[i] = gpio_out[i];
                pad_d.oe[i]  = gpio_oe[i];
            end
            // open drain drives low only
            if (!pin_output_mode_select[i] || smb_mask[i]) begin
                pad_d.oe[i]  = pad_d.oe[i] && !pad_d.out[i];
                pad_d.out[i] = 1'b0;
            end
            if (!en_q) begin
                pad_d.oe[i]  = 1'b0;
                pad_d.out[i] = 1'b0;
            end
        end
        cap_d = sync2_q & pin_digital_mode;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            pad_q   <= '0;
            fn_in_q <= '0;
            cap_q   <= '0;
        end else begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
            pad_q   <= pad_d;
            fn_in_q <= fn_in_d;
            cap_q   <= cap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_SKIP_NEVER: assert property ((owned_vec & $past(skip_all)) == 23'h0)
        else $error("skipped pin claimed");
    AST_OE_OFF: assert property (!$past(en_q) |-> pad_q.oe == 23'h0)
        else $error("driver on while crossbar disabled");
    AST_UART_FIXED: assert property
        ($past(route_a_q[0] && !skip_all[4] && !skip_all[5])
         |-> owner_q[4] == pcbx_pkg::FN_TX && owner_q[5] == pcbx_pkg::FN_RX)
        else $error("async serial not on fixed pins");
    AST_UART_OFF: assert property
        ($past(!route_a_q[0]) |-> !fn_seen[pcbx_pkg::FN_TX] && !fn_seen[pcbx_pkg::FN_RX])
        else $error("async serial routed while disabled");
    AST_NSS_B: assert property
        (fn_seen[pcbx_pkg::FN_SYNC_SERIAL_PORT_B_NSS] == $past(route_b_q[6] && ssb_4w && !skip_all[19]))
        else $error("second sync port select pin wrong");
    AST_SMB_OD: assert property ((pad_q.out & $past(smb_mask)) == 23'h0)
        else $error("two-wire pin driven high");
    AST_CHAN_RES: assert property
        ($past(route_b_q[2:0] == 3'h7) |-> fn_seen[pcbx_pkg::FN_CEX0 +: 5] == 5'h00)
        else $error("reserved channel code routed outputs");
    AST_LOWEST: assert property
        ($past(route_a_q == 8'h02 && skip_all == 23'h0 && !route_b_q[6])
         |-> owner_q[0] == pcbx_pkg::FN_SYNC_SERIAL_PORT_A_SCK && owner_q[2] == pcbx_pkg::FN_SYNC_SERIAL_PORT_A_SCK + 5'h2)
        else $error("first free pin not taken");
    AST_BAD_WRITE: assert property
        (psel && penable && pwrite && !addr_hit
         |=> $stable(route_a_q) && $stable(route_b_q) && $stable(skip0_q))
        else $error("unmapped write changed a register");
    AST_RD_B: assert property
        (psel && penable && !pwrite && idx == pcbx_pkg::IDX_ROUTE_B |-> prdata[31:7] == 25'h0)
        else $error("unused bits read nonzero");

    COV_BOTH_SERIAL: cover property (fn_seen[pcbx_pkg::FN_TX] && fn_seen[pcbx_pkg::FN_SYNC_SERIAL_PORT_A_SCK]);
    COV_FOUR_WIRE: cover property (fn_seen[pcbx_pkg::FN_SYNC_SERIAL_PORT_B_NSS]);
    COV_DRIVE: cover property (en_q && pad_q.oe != 23'h0);
    COV_ALL_CHAN: cover property (fn_seen[pcbx_pkg::FN_CEX0 + 5'h4]);
endmodule
`default_nettype wire

/* test/pcbx_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module pcbx_partner (
    // pads from the crossbar
    input  wire pcbx_pkg::pcbx_pad_t       pad,
    // peripheral drive and pad levels
    output var pcbx_pkg::pcbx_fn_t         fn_drive,
    output var logic [pcbx_pkg::NPIN-1:0]  pad_in
);
    // every function drives, even ids high, odd ids low
    always_comb begin
        fn_drive.out = 25'h1555555;
        fn_drive.oe  = 25'h1ffffff;
    end
    // released pad floats to the pull-up level
    always_comb begin
        pad_in = (pad.oe & pad.out) | ~pad.oe;
    end
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0;
    logic [31:0]          prdata;
    logic [31:0]          rd;
    logic                 pready;
    logic                 pslverr;
    logic                 err_q;
    logic                 wpo;
    logic [24:0]          fn_in_w;
    logic [22:0]          cap_w;
    logic [22:0]          dmode = 23'h7fffff;
    logic [1:0]           ssa_mode = 2'h0;
    logic [1:0]           ssb_mode = 2'h0;
    logic [22:0]          pad_in;
    pcbx_pkg::pcbx_fn_t   fn_drive;
    pcbx_pkg::pcbx_pad_t  pad;
    int                   err_total = 0;
    int                   check_count = 0;
    int                   i;

    always #5 pclk = ~pclk;

    pcbx_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fn_drive(fn_drive), .unused_fn_dummy(), .fn_in(fn_in_w),
        .ssa_mode(ssa_mode), .ssb_mode(ssb_mode), .gpio_out(23'h0), .gpio_oe(23'h0),
        .pin_output_mode_select(23'h7fffff), .pin_digital_mode(dmode),
        .capture_level(cap_w), .weak_pull_off(wpo), .pad_in(pad_in), .pad(pad));
    pcbx_partner peer (.pad(pad), .fn_drive(fn_drive), .pad_in(pad_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask
    task automatic route(input logic [7:0] a, input logic [7:0] b, input logic [23:0] exp);
        apb(1'b1, pcbx_pkg::IDX_ROUTE_A, a);
        apb(1'b1, pcbx_pkg::IDX_ROUTE_B, b);
        rdchk(pcbx_pkg::IDX_OWNED0, {24'h0, exp[7:0]});
        rdchk(pcbx_pkg::IDX_OWNED1, {24'h0, exp[15:8]});
        rdchk(pcbx_pkg::IDX_OWNED2, {24'h0, exp[23:16]});
    endtask
    task automatic give_verdict;
        $display("errors=%0d checks=%0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(pcbx_pkg::IDX_ROUTE_A, 32'h0);
        rdchk(pcbx_pkg::IDX_ROUTE_C, 32'h0);
        apb(1'b0, 10'h001, 8'h00);
        check(rd, 32'h0);
        check({31'h0, err_q}, 32'h1);
        apb(1'b1, 10'h001, 8'hff);
        check({31'h0, err_q}, 32'h1);
        rdchk(pcbx_pkg::IDX_ROUTE_A, 32'h0);
        apb(1'b1, pcbx_pkg::IDX_ROUTE_A, 8'hff);
        rdchk(pcbx_pkg::IDX_ROUTE_A, 32'hff);
        apb(1'b1, pcbx_pkg::IDX_ROUTE_B, 8'hff);
        rdchk(pcbx_pkg::IDX_ROUTE_B, 32'h7f);
        apb(1'b1, pcbx_pkg::IDX_ROUTE_C, 8'hff);
        rdchk(pcbx_pkg::IDX_ROUTE_C, 32'hc0);
        check({31'h0, wpo}, 32'h1);
        apb(1'b1, pcbx_pkg::IDX_ROUTE_C, 8'h00);
        route(8'h02, 8'h00, 24'h000007);
        ssa_mode <= 2'h1;
        route(8'h02, 8'h00, 24'h00000f);
        route(8'h07, 8'h00, 24'h0000ff);
        ssa_mode <= 2'h0;
        apb(1'b1, pcbx_pkg::IDX_SKIP0, 8'h0c);
        route(8'h03, 8'h00, 24'h000073);
        apb(1'b1, pcbx_pkg::IDX_SKIP0, 8'h10);
        route(8'h01, 8'h00, 24'h000020);
        apb(1'b1, pcbx_pkg::IDX_SKIP0, 8'hff);
        route(8'h02, 8'h00, 24'h000700);
        apb(1'b1, pcbx_pkg::IDX_SKIP1, 8'hff);
        apb(1'b1, pcbx_pkg::IDX_SKIP2, 8'hff);
        route(8'hff, 8'h7f, 24'h000000);
        apb(1'b1, pcbx_pkg::IDX_SKIP0, 8'h00);
        apb(1'b1, pcbx_pkg::IDX_SKIP1, 8'h00);
        apb(1'b1, pcbx_pkg::IDX_SKIP2, 8'h00);
        route(8'h00, 8'h40, 24'h070000);
        ssb_mode <= 2'h1;
        route(8'h02, 8'h40, 24'h0f0007);
        for (i = 0; i < 8; i++) begin
            route(8'h00, i[7:0], 24'((1 << (i < 6 ? i : (i == 6 ? 5 : 0))) - 1));
        end
        for (i = 2; i < 8; i++) begin
            route(8'(1 << i), 8'h00, (i == 2) ? 24'h3 : 24'h1);
        end
        for (i = 3; i < 6; i++) begin
            route(8'h08, 8'(1 << i), 24'h3);
        end
        route(8'h02, 8'h00, 24'h000007);
        #1;
        check(32'(pad.oe), 32'h0);
        @(posedge pclk);
        apb(1'b1, pcbx_pkg::IDX_ROUTE_C, 8'h40);
        #1;
        check(32'(pad.oe), 32'h7);
        check(32'(pad.out), 32'h5);
        @(posedge pclk);
        route(8'h04, 8'h00, 24'h000003);
        #1;
        check(32'(pad.oe), 32'h2);
        check(32'(pad.out), 32'h0);
        check(32'(fn_in_w), 32'h400);
        check(32'(cap_w), 32'h7ffffd);
        @(posedge pclk);
        dmode <= 23'h7ffffe;
        repeat (2) @(posedge pclk);
        #1;
        check(32'(cap_w), 32'h7ffffc);
        @(posedge pclk);
        route(8'h08, 8'h10, 24'h000003);
        #1;
        check(32'(pad.out), 32'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
